// >>> logic/msit_pkg.sv
// Constants and types for the multi-stop interval timer
// What this block does
// - Each of nine inputs has rising and falling enables; both clear disables it.
// - Stop pairs disabled by pins; every input also disabled by software bits.
// - Inputs open after reset; optional stop hold until start, then one-cycle (10 ns) holdoff.
// - Start lock bit blocks the start input after the first start.
// - Retrigger period zero means single start; further start pulses ignored.
// - Internal starts every N+1 reference periods, N from 4 to 255.
// - Interval from external start to first internal start is readable.
// - Eight-bit start number advances per retrigger and joins every result word.
// - Unmask bit routes start number top bit to the interrupt pin.
// - Period one plus external enable: each start retriggers, interval stored.
// - Eighteen-bit start offset added to every stop minus start result.
// - Collection pauses about 50 ns at each retrigger, then resumes.
// - Each stop keeps a 32-deep hit queue with a slope bit per entry.
// - Round-robin collection at reference rate, next channel gets priority.
// - Two output queues of 256 entries each.
// - Result bus is 28 bits, 16 bits after writing 0x10 to address 14.
// - Output enable pin low keeps the result bus driven.
// - Empty and load-level flags per queue, shared threshold in register 6.
// - Word: interval 16..0, slope 17, start number 25..18, channel 27..26.
// - Reading address 8 pops the first queue, address 9 the second.
package msit_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int REF_PERIOD_NS = 25;
    localparam int PAUSE_NS = 50;
    localparam int PAUSE_CYCLES = PAUSE_NS / CLK_PERIOD_NS;
    localparam int HOLDOFF_NS = 7;
    localparam int HOLDOFF_CYCLES = (HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIT_DEPTH = 32;
    localparam int OUT_DEPTH = 256;
    localparam int MIN_PERIOD = 4;
    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_EDGE = 4'h0;
    localparam logic [3:0] IDX_DIS = 4'h2;
    localparam logic [3:0] IDX_PERIOD = 4'h4;
    localparam logic [3:0] IDX_START = 4'h5;
    localparam logic [3:0] IDX_LOAD = 4'h6;
    localparam logic [3:0] IDX_OUT1 = 4'h8;
    localparam logic [3:0] IDX_OUT2 = 4'h9;
    localparam logic [3:0] IDX_FIRST = 4'hA;
    localparam logic [3:0] IDX_INTR = 4'hB;
    localparam logic [3:0] IDX_BUS = 4'hE;
    // Field positions
    localparam int FALL_LSB = 9;
    localparam int START_OFF_W = 18;
    localparam int HOLD_BIT = 18;
    localparam int LOCK_BIT = 19;
    localparam int EXT_BIT = 20;
    localparam int START_UNMASK_BIT = 26;
    localparam int MODE16_BIT = 4;
    // Reset values, external retrigger period and response codes
    localparam logic [8:0] EDGE_RST = 9'h1_FF;
    localparam logic [7:0] LOAD_RST = 8'h00;
    localparam logic [7:0] PERIOD_EXT = 8'h01;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic slope;
        logic [17:0] stamp;
    } msit_hit_type;

    typedef struct packed {
        logic [1:0] chan;
        logic [7:0] start_num;
        logic slope;
        logic [16:0] interval;
    } msit_word_type;
endpackage

// >>> logic/msit_timer.sv
// Eight-stop retriggerable interval timer with AXI4-Lite register access
`timescale 1ns/1ps
module msit_timer #(
    parameter int N_STOP = 8,
    parameter int HIT_DEPTH = msit_pkg::HIT_DEPTH,
    parameter int OUT_DEPTH = msit_pkg::OUT_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start_input,
    input wire logic [N_STOP-1:0] stop_input,
    input wire logic [N_STOP/2-1:0] stop_pair_disable_pin,
    input wire logic output_enable_n,
    output logic [27:0] result_bus_out,
    output logic result_bus_oe,
    output logic [1:0] queue_empty_flag,
    output logic [1:0] load_level_flag,
    output logic interrupt_pin,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import msit_pkg::*;

    // Elaboration-time refusal of geometries the logic cannot serve
    if (N_STOP != 8 || HIT_DEPTH != 32 || OUT_DEPTH != 256) begin : g_geometry_check
        $error("msit_timer: unsupported geometry");
    end

    localparam int HW = $clog2(HIT_DEPTH);
    localparam int OW = $clog2(OUT_DEPTH);

    // Configuration
    logic [8:0] rising_edge_enable;
    logic [8:0] falling_edge_enable;
    logic [8:0] sw_disable;
    logic [7:0] retrigger_period;
    logic [17:0] start_offset;
    logic stop_hold_until_start;
    logic start_lock_after_first;
    logic external_retrigger_enable;
    logic [7:0] load_threshold;
    logic start_unmask;
    logic mode16;

    // Timebase and start state
    logic [17:0] time_cnt;
    logic [4:0] ref_acc;
    logic ref_tick;
    logic [7:0] ref_cnt;
    logic started;
    logic [3:0] holdoff;
    logic [17:0] start_stamp;
    logic [7:0] start_num;
    logic first_pending;
    logic [16:0] first_start_interval;
    logic [3:0] pause_cnt;
    logic [8:0] in_prev;
    logic [8:0] in_now;
    logic [8:0] edge_hit;
    logic [8:0] edge_slope;
    logic start_accept;
    logic int_start;
    logic ext_retrig;
    logic internal_mode;

    function automatic logic [8:0] edges_of(input logic [8:0] now, input logic [8:0] prev,
                                            input logic [8:0] rise, input logic [8:0] fall);
        edges_of = (now & ~prev & rise) | (~now & prev & fall);
    endfunction

    assign in_now = {stop_input, start_input};
    assign edge_hit = edges_of(in_now, in_prev, rising_edge_enable, falling_edge_enable);
    assign edge_slope = in_now;
    assign internal_mode = retrigger_period >= 8'(MIN_PERIOD);
    assign ext_retrig = retrigger_period == PERIOD_EXT && external_retrigger_enable;
    // After the first start, a start is ignored when locked or when no external retrigger is in use
    assign start_accept = edge_hit[0] && !sw_disable[0] &&
        !(started && (start_lock_after_first || !ext_retrig));
    assign int_start = started && internal_mode && ref_tick && ref_cnt == retrigger_period;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            in_prev <= '0;
            time_cnt <= '0;
            ref_acc <= '0;
        end else begin
            in_prev <= in_now;
            time_cnt <= time_cnt + 18'h0_0001;
            ref_acc <= ref_tick ? 5'(ref_acc + CLK_PERIOD_NS - REF_PERIOD_NS)
                                : 5'(ref_acc + CLK_PERIOD_NS);
        end
    end
    // 40 MHz reference tick from the 100 MHz clock, exact on average
    assign ref_tick = 32'(ref_acc) + CLK_PERIOD_NS >= REF_PERIOD_NS;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            started <= 1'b0;
            holdoff <= '0;
            start_stamp <= '0;
            start_num <= '0;
            first_pending <= 1'b0;
            first_start_interval <= '0;
            ref_cnt <= '0;
            pause_cnt <= '0;
        end else begin
            if (holdoff != 0) begin
                holdoff <= holdoff - 4'h1;
            end
            if (pause_cnt != 0) begin
                pause_cnt <= pause_cnt - 4'h1;
            end
            if (ref_tick && started) begin
                ref_cnt <= int_start ? 8'h00 : ref_cnt + 8'h01;
            end
            if (start_accept && !started) begin
                started <= 1'b1;
                holdoff <= 4'(HOLDOFF_CYCLES);
                start_stamp <= time_cnt;
                start_num <= '0;
                first_pending <= 1'b1;
                ref_cnt <= '0;
            end else if (start_accept && ext_retrig) begin
                first_start_interval <= 17'(time_cnt - start_stamp);
                start_stamp <= time_cnt;
                start_num <= start_num + 8'h01;
                pause_cnt <= 4'(PAUSE_CYCLES);
            end else if (int_start) begin
                if (first_pending) begin
                    first_start_interval <= 17'(time_cnt - start_stamp);
                end
                first_pending <= 1'b0;
                start_stamp <= time_cnt;
                start_num <= start_num + 8'h01;
                pause_cnt <= 4'(PAUSE_CYCLES);
            end
        end
    end

    assign interrupt_pin = start_unmask && start_num[7];

    // Stop hit queues
    msit_hit_type hq_mem [N_STOP][HIT_DEPTH];
    logic [HW:0] hq_wr [N_STOP];
    logic [HW:0] hq_rd [N_STOP];
    logic [N_STOP-1:0] hq_push;
    logic [N_STOP-1:0] hq_pop;
    logic [N_STOP-1:0] hq_avail;

    always_comb begin
        for (int k = 0; k < N_STOP; k++) begin
            hq_avail[k] = hq_wr[k] != hq_rd[k];
            hq_push[k] = edge_hit[k+1] && !sw_disable[k+1] && !stop_pair_disable_pin[k/2] &&
                !(stop_hold_until_start && (!started || holdoff != 0)) &&
                (hq_wr[k] - hq_rd[k]) != (HW+1)'(HIT_DEPTH);
        end
    end

    always_ff @(posedge core_clk) begin
        for (int k = 0; k < N_STOP; k++) begin
            if (!rst_n) begin
                hq_wr[k] <= '0;
                hq_rd[k] <= '0;
            end else begin
                if (hq_push[k]) begin
                    hq_mem[k][hq_wr[k][HW-1:0]] <= '{slope: edge_slope[k+1], stamp: time_cnt};
                    hq_wr[k] <= hq_wr[k] + 1'b1;
                end
                if (hq_pop[k]) begin
                    hq_rd[k] <= hq_rd[k] + 1'b1;
                end
            end
        end
    end

    // Round-robin collection into the output queues
    logic [2:0] rr_ptr;
    logic [2:0] rr_sel;
    logic rr_found;
    logic [OW:0] oq_cnt [2];
    logic [OW-1:0] oq_wr [2];
    logic [OW-1:0] oq_rd [2];
    logic [27:0] oq_mem [2][OUT_DEPTH];
    logic [1:0] oq_push;
    logic [1:0] oq_pop;
    msit_word_type push_word;
    msit_hit_type head;

    always_comb begin
        rr_sel = rr_ptr;
        rr_found = 1'b0;
        for (int i = N_STOP - 1; i >= 0; i--) begin
            if (hq_avail[3'(rr_ptr + 3'(i))]) begin
                rr_sel = 3'(rr_ptr + 3'(i));
                rr_found = 1'b1;
            end
        end
    end

    assign head = hq_mem[rr_sel][hq_rd[rr_sel][HW-1:0]];
    assign push_word.chan = rr_sel[1:0];
    assign push_word.start_num = start_num;
    assign push_word.slope = head.slope;
    assign push_word.interval = 17'(head.stamp - start_stamp + start_offset);

    always_comb begin
        oq_push = '0;
        hq_pop = '0;
        // Transfer paced by the reference tick and halted during retrigger
        if (ref_tick && rr_found && pause_cnt == 0 && !int_start &&
            oq_cnt[rr_sel[2]] != (OW+1)'(OUT_DEPTH)) begin
            oq_push[rr_sel[2]] = 1'b1;
            hq_pop[rr_sel] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rr_ptr <= '0;
        end else if (oq_push != 0) begin
            rr_ptr <= rr_sel + 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        for (int q = 0; q < 2; q++) begin
            if (!rst_n) begin
                oq_cnt[q] <= '0;
                oq_wr[q] <= '0;
                oq_rd[q] <= '0;
            end else begin
                if (oq_push[q]) begin
                    oq_mem[q][oq_wr[q]] <= push_word;
                    oq_wr[q] <= oq_wr[q] + 1'b1;
                end
                if (oq_pop[q]) begin
                    oq_rd[q] <= oq_rd[q] + 1'b1;
                end
                oq_cnt[q] <= oq_cnt[q] + (OW+1)'(oq_push[q]) - (OW+1)'(oq_pop[q]);
            end
        end
    end

    always_comb begin
        for (int q = 0; q < 2; q++) begin
            queue_empty_flag[q] = oq_cnt[q] == 0;
            load_level_flag[q] = oq_cnt[q] >= (OW+1)'(load_threshold) && load_threshold != 0;
        end
    end

    // AXI4-Lite write side
    logic aw_held;
    logic w_held;
    logic [3:0] aw_idx;
    logic [31:0] w_data;
    logic wr_fire;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= '0;
            w_data <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_idx <= s_axi_awaddr[5:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_idx inside {IDX_EDGE, IDX_DIS, IDX_PERIOD, IDX_START,
                    IDX_LOAD, IDX_INTR, IDX_BUS} ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rising_edge_enable <= EDGE_RST;
            falling_edge_enable <= '0;
            sw_disable <= '0;
            retrigger_period <= '0;
            start_offset <= '0;
            stop_hold_until_start <= 1'b0;
            start_lock_after_first <= 1'b0;
            external_retrigger_enable <= 1'b0;
            load_threshold <= LOAD_RST;
            start_unmask <= 1'b0;
            mode16 <= 1'b0;
        end else if (wr_fire) begin
            case (aw_idx)
                IDX_EDGE: begin
                    rising_edge_enable <= w_data[8:0];
                    falling_edge_enable <= w_data[FALL_LSB +: 9];
                end
                IDX_DIS: sw_disable <= w_data[8:0];
                IDX_PERIOD: retrigger_period <= w_data[7:0];
                IDX_START: begin
                    start_offset <= w_data[START_OFF_W-1:0];
                    stop_hold_until_start <= w_data[HOLD_BIT];
                    start_lock_after_first <= w_data[LOCK_BIT];
                    external_retrigger_enable <= w_data[EXT_BIT];
                end
                IDX_LOAD: load_threshold <= w_data[7:0];
                IDX_INTR: start_unmask <= w_data[START_UNMASK_BIT];
                IDX_BUS: mode16 <= w_data[MODE16_BIT];
                default: ;
            endcase
        end
    end

    // AXI4-Lite read side; a queue read pops one word, in 16-bit mode only on the high-half read
    logic [3:0] ar_idx;
    logic [27:0] rd_word;
    logic rd_ok;
    logic half_hi;
    logic rd_fire;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign ar_idx = s_axi_araddr[5:2];

    always_comb begin
        rd_ok = 1'b1;
        rd_word = '0;
        oq_pop = '0;
        case (ar_idx)
            IDX_EDGE: rd_word = 28'({falling_edge_enable, rising_edge_enable});
            IDX_DIS: rd_word = 28'(sw_disable);
            IDX_PERIOD: rd_word = 28'(retrigger_period);
            IDX_START: rd_word = 28'({external_retrigger_enable, start_lock_after_first,
                                      stop_hold_until_start, start_offset});
            IDX_LOAD: rd_word = 28'(load_threshold);
            IDX_OUT1, IDX_OUT2: begin
                rd_word = oq_mem[ar_idx[0]][oq_rd[ar_idx[0]]];
                // Pop on the full word, or on the high half in 16-bit mode
                oq_pop[ar_idx[0]] = rd_fire && !queue_empty_flag[ar_idx[0]] &&
                    (!mode16 || half_hi);
            end
            IDX_FIRST: rd_word = 28'(first_start_interval);
            IDX_INTR: rd_word = 28'(start_unmask) << START_UNMASK_BIT;
            IDX_BUS: rd_word = 28'(mode16) << MODE16_BIT;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
            half_hi <= 1'b0;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            if (mode16) begin
                s_axi_rdata <= half_hi ? 32'(rd_word[27:16]) : 32'(rd_word[15:0]);
                half_hi <= !half_hi;
            end else begin
                s_axi_rdata <= 32'(rd_word);
                half_hi <= 1'b0;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign result_bus_out = s_axi_rdata[27:0];
    assign result_bus_oe = !output_enable_n || s_axi_rvalid;

    // Checks
    logic [4:0] since_int;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            since_int <= 5'h1F;
        end else begin
            since_int <= int_start ? 5'h00 : (since_int == 5'h1F ? since_int : since_int + 5'h01);
        end
    end

    edge_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        hq_push[0] |-> $past(rising_edge_enable[1]) || $past(falling_edge_enable[1]) ||
        rising_edge_enable[1] || falling_edge_enable[1])
        else $error("hit stored on an input with no edge enabled");
    pair_disable_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        stop_pair_disable_pin[2] |-> ##1 $stable(hq_wr[4]) && $stable(hq_wr[5]))
        else $error("disabled stop pair stored a hit");
    stop_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        stop_hold_until_start && !started |-> hq_push == 0)
        else $error("stop accepted before start");
    start_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        start_lock_after_first && started |-> !start_accept)
        else $error("start taken after lock");
    retrig_space_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        int_start |-> since_int >= 5'd11)
        else $error("internal starts too close");
    retrig_pause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        int_start |=> (oq_push == 0) [*5])
        else $error("collection ran during retrigger pause");
    start_count_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        int_start |=> start_num == $past(start_num) + 8'h01)
        else $error("start number did not advance");
    word_chan_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        oq_push != 0 |=> oq_cnt[$past(rr_sel[2])] != 0 && rr_ptr == $past(rr_sel) + 3'h1)
        else $error("collection did not advance");
    intr_mask_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !start_unmask |-> !interrupt_pin)
        else $error("interrupt pin driven while masked");
endmodule

// >>> tb/msit_host.sv
// Host model: AXI4-Lite master that collects results
`timescale 1ns/1ps
module msit_host (
    input wire logic core_clk,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic [5:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    output logic s_axi_bready,
    output logic [5:0] s_axi_araddr,
    output logic s_axi_arvalid,
    output logic s_axi_rready,
    output logic stuck
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, stuck} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_wstrb, s_axi_bready, s_axi_rready} = 13'h003F;
    end
    task automatic wr(input logic [3:0] i, input logic [31:0] d, output logic [1:0] r);
        logic ah, wh, bh;
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {i, 2'b00, d, 2'b11};
        repeat (40) begin
            @(negedge core_clk);
            ah = s_axi_awvalid & s_axi_awready;
            wh = s_axi_wvalid & s_axi_wready;
            bh = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) return;
        end
        stuck <= 1'b1;
    endtask
    task automatic rd(input logic [3:0] i, output logic [31:0] d, output logic [1:0] r);
        logic ah, rh;
        {s_axi_araddr, s_axi_arvalid} <= {i, 3'b001};
        repeat (40) begin
            @(negedge core_clk);
            ah = s_axi_arvalid & s_axi_arready;
            rh = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) return;
        end
        stuck <= 1'b1;
    endtask
endmodule

// >>> tb/tb_multi_stop_interval_timer.sv
// Bench for the multi-stop interval timer
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_multi_stop_interval_timer;
    import msit_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n, start_input, output_enable_n, result_bus_oe, interrupt_pin, stuck;
    logic [7:0] stop_input;
    logic [3:0] stop_pair_disable_pin, s_axi_wstrb;
    logic [27:0] result_bus_out, x;
    logic [1:0] queue_empty_flag, load_level_flag, s_axi_bresp, s_axi_rresp, rr;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, w;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [17:0] off;
    int bad_count = 0, checked = 0, cyc = 0, t0, t, t1, p;
    msit_timer u_msit_timer (.*);
    msit_host u_msit_host (.*);
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    always @(posedge stuck) begin
        bad_count++;
        report_and_stop();
    end
    task automatic report_and_stop();
        if (bad_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic clk(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    function automatic logic [27:0] word(logic [1:0] ch, logic sl, int iv);
        return {ch, 8'h00, sl, 17'(iv)};
    endfunction
    task automatic pulse(input logic [7:0] m);
        stop_input <= m;
        t = cyc;
        clk(1);
        stop_input <= 8'h00;
    endtask
    task automatic fire();
        start_input <= 1'b1;
        t0 = cyc;
        clk(1);
        start_input <= 1'b0;
    endtask
    // Reads a queue only when its empty flag is low
    task automatic pop(input int q, input logic [27:0] x);
        logic em;
        @(negedge core_clk);
        em = queue_empty_flag[q];
        `CHK(em, 1'b0)
        @(posedge core_clk);
        if (em === 1'b0) u_msit_host.rd(q[0] ? IDX_OUT2 : IDX_OUT1, w, rr);
        `CHK(w[27:0], x)
        `CHK(result_bus_out, x)
    endtask
    initial begin
        {rst_n, start_input, output_enable_n, stop_input, stop_pair_disable_pin} = 15'h1000;
        void'($urandom(32'h988b_6db5));
        clk(8);
        rst_n <= 1'b1;
        output_enable_n <= 1'b0;
        @(negedge core_clk);
        `CHK({queue_empty_flag, load_level_flag, interrupt_pin, result_bus_oe}, 6'h31)
        clk(1);
        output_enable_n <= 1'b1;
        u_msit_host.rd(IDX_EDGE, w, rr);
        `CHK(w[17:0], {9'h000, EDGE_RST})
        u_msit_host.rd(4'h7, w, rr);
        `CHK({rr, w}, {RESP_SLVERR, 32'h0000_0000})
        u_msit_host.wr(IDX_OUT1, 32'h0000_0000, rr);
        `CHK(rr, RESP_SLVERR)
        off = 18'($urandom_range(4095));
        u_msit_host.wr(IDX_START, {14'h0000, off}, rr);
        fire();
        // Random stops against one start; a second start is ignored
        for (int i = 0; i < 24; i++) begin
            int j;
            j = $urandom_range(7);
            p = (j + 1) % 8;
            if (i == 5) start_input <= 1'b1;
            clk($urandom_range(9, 3));
            start_input <= 1'b0;
            pulse(8'(1 << j));
            clk(10);
            pop(j / 4, word(2'(j % 4), 1'b1, t - t0 + off));
        end
        u_msit_host.wr(IDX_LOAD, 32'h0000_0004, rr);
        pulse(8'hFF);
        clk(40);
        @(negedge core_clk);
        `CHK(load_level_flag, 2'b11)
        clk(1);
        // Round robin starts at the neighbour of the last stop served
        for (int k = 0; k < 8; k++) begin
            pop(((p + k) % 8) / 4, word(2'((p + k) % 4), 1'b1, t - t0 + off));
        end
        @(negedge core_clk);
        `CHK({queue_empty_flag, load_level_flag}, 4'hC)
        clk(1);
        // Stop 3 by software, stops 5-6 by pin, stop 8 edges off, stop 1 falling
        u_msit_host.wr(IDX_DIS, 32'h0000_0008, rr);
        u_msit_host.wr(IDX_EDGE, {14'h0000, 9'h002, 9'h0FD}, rr);
        stop_pair_disable_pin <= 4'h4;
        clk(1);
        pulse(8'hB5);
        clk(20);
        pop(0, word(2'h0, 1'b0, t + 1 - t0 + off));
        @(negedge core_clk);
        `CHK(queue_empty_flag, 2'b11)
        clk(1);
        // External retrigger, then a start that the lock must refuse
        u_msit_host.wr(IDX_PERIOD, 32'h0000_0001, rr);
        u_msit_host.wr(IDX_START, 32'h0010_0000, rr);
        t1 = t0;
        fire();
        clk(10);
        u_msit_host.rd(IDX_FIRST, w, rr);
        `CHK(w[16:0], 17'(t0 - t1))
        t1 = t0;
        u_msit_host.wr(IDX_START, 32'h0018_0000, rr);
        fire();
        pulse(8'h02);
        clk(20);
        pop(0, word(2'h1, 1'b1, t - t1) | 28'h004_0000);
        // 16-bit bus: low half first, the high half pops
        u_msit_host.wr(IDX_BUS, 32'h0000_0010, rr);
        pulse(8'h02);
        clk(20);
        x = word(2'h1, 1'b1, t - t1) | 28'h004_0000;
        u_msit_host.rd(IDX_OUT1, w, rr);
        `CHK(w, 32'(x[15:0]))
        u_msit_host.rd(IDX_OUT1, w, rr);
        `CHK(w, 32'(x[27:16]))
        @(negedge core_clk);
        `CHK(queue_empty_flag, 2'b11)
        clk(1);
        rst_n <= 1'b0;
        stop_pair_disable_pin <= 4'h0;
        clk(2);
        rst_n <= 1'b1;
        clk(1);
        u_msit_host.wr(IDX_START, 32'h0004_0000, rr);
        u_msit_host.wr(IDX_PERIOD, 32'h0000_0004, rr);
        u_msit_host.wr(IDX_INTR, 32'h0400_0000, rr);
        pulse(8'h01);
        clk(20);
        @(negedge core_clk);
        `CHK(queue_empty_flag, 2'b11)
        `CHK(result_bus_oe, 1'b0)
        clk(1);
        fire();
        clk(2);
        pulse(8'h02);
        clk(20);
        pop(0, word(2'h1, 1'b1, t - t0));
        u_msit_host.rd(IDX_FIRST, w, rr);
        `CHK(w[16:0] inside {[10:15]}, 1'b1)
        clk(1150);
        @(negedge core_clk);
        `CHK(interrupt_pin, 1'b0)
        clk(600);
        @(negedge core_clk);
        `CHK(interrupt_pin, 1'b1)
        report_and_stop();
    end
endmodule
